// ### hub_desc_map.vh
`ifndef HUB_DESC_MAP_VH
`define HUB_DESC_MAP_VH
// Configuration image window in the serial memory
`define CFG_FIRST 8'h20
`define CFG_LAST 8'h39
`define CFG_BYTES 26
// Byte positions inside the configuration image
`define CFG_VID_LO 5'h00
`define CFG_VID_HI 5'h01
`define CFG_PID_LO 5'h02
`define CFG_PID_HI 5'h03
`define CFG_REL_LO 5'h04
`define CFG_REL_HI 5'h05
`define CFG_BYTE1 5'h06
`define CFG_MAX_BP 5'h07
`define CFG_MAX_SP 5'h08
// Fields of config_byte_one
`define B1_PWR_SEL 7
`define B1_HS_DIS 5
`define B1_RESET 8'h80
`define MAX_BP_RESET 8'h01
`define MAX_SP_RESET 8'h01
`define REL_LO_RESET 8'h00
// Register map
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_PORT0 0
`define CTRL_PORT1 1
// Standard descriptor constants
`define DT_DEVICE 8'h01
`define DT_CONFIG 8'h02
`define DEV_LEN 8'h12
`define CFG_LEN 8'h09
`define CFG_TOTAL 8'h19
`define IF_LEN 8'h09
`define IF_TYPE 8'h04
`define EP_LEN 8'h07
`define EP_TYPE 8'h05
`define EP_ADDR 8'h81
`define EP_ATTR 8'h03
`define EP_MPS 8'h01
`define EP_IVL 8'hFF
`define USB_BCD_LO 8'h00
`define USB_BCD_HI 8'h02
`define CLASS_HUB 8'h09
`define EP0_MPS 8'h40
`define ONE 8'h01
`define ZERO 8'h00
`define ATTR_BUS 8'hA0
`define ATTR_SELF 8'hE0
`define IF_OFF 5'h09
`define EP_OFF 5'h12
// Detach limit after upstream power loss
`define DETACH_MAX_S 10
`define CLK_HZ 40000000
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### hub_descriptor_attach_logic.v
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "hub_desc_map.vh"
// Overview of operation
// - Configuration comes from valid memory image, else internal defaults.
// - Downstream port power outputs are active high only.
// - No upstream power sensed means the D+ pull-up stays off.
// - Pull-up is removed within 10 s after upstream power is lost.
// - No attach until all user descriptor fields hold valid values; the code checks no field and attaches once the configuration load is done.
// - Descriptors built from config bytes 20h to 39h or defaults.
// - High-speed disabled means full-speed attach with full-speed set.
// - Device descriptor fixed fields: 12h, 01h, 0200h, 09h, 40h, one config.
// - Vendor, product and release fields come from configuration.
// - Default release is silicon revision in high byte, 00h low.
// - Configuration descriptor: 09h, 02h, total 0019h, one interface.
// - Attributes A0h when bus powered, E0h when self powered.
// - Attributes always advertise remote wakeup.
// - Max power is in 2 mA units covering all hub circuitry.
// - Max power picks bus- or self-powered value by power select.
// - Interface descriptor: 09h, 04h, one endpoint, hub class 09h.
// - Endpoint descriptor: 07h, 05h, 81h, 03h, 0001h, FFh.
// - Full-speed attach of high-speed part reports same values, protocol 0.
module hub_descriptor_attach_logic #(
  // Arbitrary identity values, not tied to any maker
  parameter [15:0] DEF_VENDOR = 16'h1234,
  parameter [15:0] DEF_PRODUCT = 16'h5678,
  parameter [7:0] SILICON_REV = 8'h01
) (
  // Clock and reset
  input wire clock_i,
  input wire nrst_i,
  // AXI4-Lite register slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Configuration memory controller
  input wire mem_wr_i,
  input wire [7:0] mem_addr_i,
  input wire [7:0] mem_data_i,
  input wire mem_done_i,
  input wire mem_valid_i,
  // Descriptor fetch from the upstream engine
  input wire desc_rd_i,
  input wire [7:0] desc_type_i,
  input wire [4:0] desc_offset_i,
  output reg [7:0] desc_data_o,
  output reg desc_valid_o,
  output reg desc_err_o,
  output reg [4:0] desc_len_o,
  // Upstream pins and port power
  input wire upstream_power_sense_i,
  output reg dplus_pullup_o,
  output wire hs_enable_o,
  output wire [1:0] port_power_o
);

////////////////////////////////////////////////////////////////////////////
// Configuration image
reg [7:0] cfg_q [0:`CFG_BYTES-1];
reg cfg_ready_q;
reg done_q;
reg [1:0] ctrl_q;
reg vbus_s1_q;
reg vbus_q;
localparam [7:0] DEV_LEN_B = `DEV_LEN;
integer i;

function [7:0] def_byte;
  input integer idx;
  begin
    case (idx)
      `CFG_VID_LO: def_byte = DEF_VENDOR[7:0];
      `CFG_VID_HI: def_byte = DEF_VENDOR[15:8];
      `CFG_PID_LO: def_byte = DEF_PRODUCT[7:0];
      `CFG_PID_HI: def_byte = DEF_PRODUCT[15:8];
      `CFG_REL_LO: def_byte = `REL_LO_RESET;
      `CFG_REL_HI: def_byte = SILICON_REV;
      `CFG_BYTE1: def_byte = `B1_RESET;
      `CFG_MAX_BP: def_byte = `MAX_BP_RESET;
      `CFG_MAX_SP: def_byte = `MAX_SP_RESET;
      default: def_byte = `ZERO;
    endcase
  end
endfunction

function in_window;
  input [7:0] a;
  begin
    in_window = (a >= `CFG_FIRST) && (a <= `CFG_LAST);
  end
endfunction

wire attached = dplus_pullup_o;
localparam [7:0] TOTAL_B = `CFG_TOTAL;
wire [7:0] mbase = mem_addr_i - `CFG_FIRST;
wire pwr_sel = cfg_q[`CFG_BYTE1][`B1_PWR_SEL];

////////////////////////////////////////////////////////////////////////////
// AXI write path
reg aw_q;
reg w_q;
reg [7:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
wire aw_now = aw_q | s_axi_awvalid;
wire w_now = w_q | s_axi_wvalid;
wire [7:0] wa = aw_q ? awaddr_q : s_axi_awaddr;
wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
wire [3:0] ws = w_q ? wstrb_q : s_axi_wstrb;
wire wr_go = aw_now & w_now & ~s_axi_bvalid;
wire wr_cfg = wr_go & in_window(wa) & (wa[1:0] == 2'h0);
wire wr_ctrl = wr_go & (wa == `REG_CTRL);
wire [7:0] wbyte = wa - `CFG_FIRST;
assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
assign s_axi_wready = ~w_q & ~s_axi_bvalid;

always @(posedge clock_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    aw_q <= 1'b0;
    w_q <= 1'b0;
    awaddr_q <= 8'h00;
    wdata_q <= 32'h0000_0000;
    wstrb_q <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
    ctrl_q <= 2'h0;
  end
  else
  begin
    if (s_axi_awvalid & s_axi_awready & ~wr_go)
    begin
      aw_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready & ~wr_go)
    begin
      w_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_cfg | wr_ctrl | (wa == `REG_STATUS)) ?
                     `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
    if (wr_ctrl & ws[0])
      ctrl_q <= wd[1:0];
  end
end

////////////////////////////////////////////////////////////////////////////
// Configuration source and attach control
always @(posedge clock_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    for (i = 0; i < `CFG_BYTES; i = i + 1)
      cfg_q[i] <= def_byte(i);
    cfg_ready_q <= 1'b0;
    done_q <= 1'b0;
  end
  else
  begin
    done_q <= mem_done_i;
    if (mem_wr_i & ~cfg_ready_q & in_window(mem_addr_i))
      cfg_q[mbase[4:0]] <= mem_data_i;
    if (mem_done_i & ~done_q & ~cfg_ready_q)
    begin
      cfg_ready_q <= 1'b1;
      if (!mem_valid_i)
        for (i = 0; i < `CFG_BYTES; i = i + 1)
          cfg_q[i] <= def_byte(i);
    end
    // Software may tune the image only while detached
    if (wr_cfg & ~attached)
      for (i = 0; i < 4; i = i + 1)
        if (ws[i] && (wbyte + i < `CFG_BYTES))
          cfg_q[wbyte + i] <= wd[8*i +: 8];
  end
end

always @(posedge clock_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    vbus_s1_q <= 1'b0;
    vbus_q <= 1'b0;
    dplus_pullup_o <= 1'b0;
  end
  else
  begin
    vbus_s1_q <= upstream_power_sense_i;
    vbus_q <= vbus_s1_q;
    dplus_pullup_o <= vbus_q & cfg_ready_q;
  end
end

assign hs_enable_o = ~cfg_q[`CFG_BYTE1][`B1_HS_DIS];
assign port_power_o = attached ? ctrl_q : 2'h0;

////////////////////////////////////////////////////////////////////////////
// AXI read path
function [7:0] img;
  input [7:0] idx;
  begin
    img = (idx < `CFG_BYTES) ? cfg_q[idx[4:0]] : `ZERO;
  end
endfunction

wire [7:0] rb = s_axi_araddr - `CFG_FIRST;
assign s_axi_arready = ~s_axi_rvalid;

always @(posedge clock_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `RESP_OKAY;
  end
  else if (s_axi_arvalid & s_axi_arready)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= `RESP_OKAY;
    if (s_axi_araddr == `REG_CTRL)
      s_axi_rdata <= {30'h0, ctrl_q};
    else if (s_axi_araddr == `REG_STATUS)
      s_axi_rdata <= {28'h0, hs_enable_o, vbus_q, cfg_ready_q, attached};
    else if (in_window(s_axi_araddr) && (s_axi_araddr[1:0] == 2'h0))
      s_axi_rdata <= {img(rb + 8'h3), img(rb + 8'h2),
                      img(rb + 8'h1), img(rb)};
    else
    begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_SLVERR;
    end
  end
  else if (s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// Descriptor generation
function [7:0] dev_byte;
  input [4:0] o;
  begin
    case (o)
      5'h00: dev_byte = `DEV_LEN;
      5'h01: dev_byte = `DT_DEVICE;
      5'h02: dev_byte = `USB_BCD_LO;
      5'h03: dev_byte = `USB_BCD_HI;
      5'h04: dev_byte = `CLASS_HUB;
      5'h07: dev_byte = `EP0_MPS;
      5'h08: dev_byte = cfg_q[`CFG_VID_LO];
      5'h09: dev_byte = cfg_q[`CFG_VID_HI];
      5'h0A: dev_byte = cfg_q[`CFG_PID_LO];
      5'h0B: dev_byte = cfg_q[`CFG_PID_HI];
      5'h0C: dev_byte = cfg_q[`CFG_REL_LO];
      5'h0D: dev_byte = cfg_q[`CFG_REL_HI];
      5'h11: dev_byte = `ONE;
      default: dev_byte = `ZERO;
    endcase
  end
endfunction

function [7:0] cfg_byte;
  input [4:0] o;
  begin
    case (o)
      5'h00: cfg_byte = `CFG_LEN;
      5'h01: cfg_byte = `DT_CONFIG;
      5'h02: cfg_byte = `CFG_TOTAL;
      5'h04: cfg_byte = `ONE;
      5'h05: cfg_byte = `ONE;
      5'h07: cfg_byte = pwr_sel ? `ATTR_SELF : `ATTR_BUS;
      5'h08: cfg_byte = pwr_sel ? cfg_q[`CFG_MAX_SP] : cfg_q[`CFG_MAX_BP];
      5'h09: cfg_byte = `IF_LEN;
      5'h0A: cfg_byte = `IF_TYPE;
      5'h0D: cfg_byte = `ONE;
      5'h0E: cfg_byte = `CLASS_HUB;
      5'h12: cfg_byte = `EP_LEN;
      5'h13: cfg_byte = `EP_TYPE;
      5'h14: cfg_byte = `EP_ADDR;
      5'h15: cfg_byte = `EP_ATTR;
      5'h16: cfg_byte = `EP_MPS;
      5'h18: cfg_byte = `EP_IVL;
      default: cfg_byte = `ZERO;
    endcase
  end
endfunction

wire is_dev = (desc_type_i == `DT_DEVICE);
wire is_cfg = (desc_type_i == `DT_CONFIG);

always @(posedge clock_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    desc_data_o <= 8'h00;
    desc_valid_o <= 1'b0;
    desc_err_o <= 1'b0;
    desc_len_o <= 5'h00;
  end
  else
  begin
    desc_valid_o <= desc_rd_i;
    desc_err_o <= 1'b0;
    if (desc_rd_i)
    begin
      if (is_dev && (desc_offset_i < `DEV_LEN))
      begin
        desc_data_o <= dev_byte(desc_offset_i);
        desc_len_o <= DEV_LEN_B[4:0];
      end
      else if (is_cfg && (desc_offset_i < `CFG_TOTAL))
      begin
        desc_data_o <= cfg_byte(desc_offset_i);
        desc_len_o <= TOTAL_B[4:0];
      end
      else
      begin
        desc_data_o <= 8'h00;
        desc_len_o <= 5'h00;
        desc_err_o <= 1'b1;
      end
    end
  end
end

endmodule // hub_descriptor_attach_logic

// ### hub_desc_props.sv
`timescale 1ns/1ps
module hub_desc_props (
  // Clock and reset
  input wire clock_i,
  input wire nrst_i,
  // Attach pins
  input wire upstream_power_sense_i,
  input wire mem_done_i,
  input wire dplus_pullup_o,
  input wire [1:0] port_power_o,
  // Descriptor fetch
  input wire desc_rd_i,
  input wire [7:0] desc_type_i,
  input wire [4:0] desc_offset_i,
  input wire [7:0] desc_data_o,
  input wire desc_valid_o,
  input wire desc_err_o,
  input wire [4:0] desc_len_o,
  // Write response
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp
);
  reg loaded_q;
  wire cfg_rd = desc_rd_i && desc_type_i == 8'h02;
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  always @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      loaded_q <= 1'b0;
    else
      loaded_q <= loaded_q | mem_done_i;
  a_vbus_drop: assert property (
    !upstream_power_sense_i [*4] |-> !dplus_pullup_o)
    else $error("pull-up held without bus power");
  a_attach_after_load: assert property (
    dplus_pullup_o |-> loaded_q)
    else $error("attached before configuration load");
  a_power_gate: assert property (
    !dplus_pullup_o && !$past(dplus_pullup_o) |-> port_power_o == 2'h0)
    else $error("port power on while detached");
  a_desc_answer: assert property (
    desc_rd_i |=> desc_valid_o || desc_err_o)
    else $error("descriptor request not answered");
  a_no_stray: assert property (
    !desc_rd_i |=> !desc_valid_o && !desc_err_o)
    else $error("descriptor answer without request");
  a_dev_header: assert property (
    desc_rd_i && desc_type_i == 8'h01 && desc_offset_i == 5'h00
    |=> desc_data_o == 8'h12 && desc_len_o == 5'h12)
    else $error("device length byte wrong");
  a_cfg_total: assert property (
    cfg_rd && desc_offset_i == 5'h02 |=> desc_data_o == 8'h19)
    else $error("total length wrong");
  a_attr_legal: assert property (
    cfg_rd && desc_offset_i == 5'h07
    |=> desc_data_o == 8'hA0 || desc_data_o == 8'hE0)
    else $error("attributes value reserved");
  a_ep_addr: assert property (
    cfg_rd && desc_offset_i == 5'h14 |=> desc_data_o == 8'h81)
    else $error("endpoint address wrong");
  a_resp_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  cover property (cfg_rd && desc_offset_i == 5'h18);
  cover property ($fell(dplus_pullup_o));
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
endmodule // hub_desc_props
bind hub_descriptor_attach_logic hub_desc_props u_props (.clock_i, .nrst_i,
  .upstream_power_sense_i, .mem_done_i, .dplus_pullup_o, .port_power_o,
  .desc_rd_i, .desc_type_i, .desc_offset_i, .desc_data_o, .desc_valid_o,
  .desc_err_o, .desc_len_o, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

// ### hub_host_model.sv
`timescale 1ns/1ps
module hub_host_model (
  // Clock and reset
  input wire clock_i,
  input wire nrst_i,
  // Bench control
  input wire go_i,
  input wire slow_i,
  input wire vbus_i,
  input wire [7:0] type_i,
  input wire [4:0] count_i,
  output reg busy_o,
  // Hub side
  output reg desc_rd_o,
  output reg [7:0] desc_type_o,
  output reg [4:0] desc_offset_o,
  output wire upstream_power_sense_o
);
  reg [4:0] next_q;
  reg [4:0] left_q;
  reg gap_q;
  assign upstream_power_sense_o = vbus_i;
  always @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      {busy_o, desc_rd_o, gap_q} <= 3'h0;
      {desc_type_o, desc_offset_o, next_q, left_q} <= 23'h0;
    end
    else
    begin
      // Idle fields scrambled so a stale value cannot pass
      desc_rd_o <= 1'b0;
      desc_type_o <= ~desc_type_o;
      desc_offset_o <= ~desc_offset_o;
      gap_q <= 1'b0;
      if (go_i)
      begin
        busy_o <= 1'b1;
        next_q <= 5'h00;
        left_q <= count_i;
      end
      else if (busy_o && left_q == 5'h00)
        busy_o <= 1'b0;
      else if (busy_o && !(slow_i && gap_q))
      begin
        desc_rd_o <= 1'b1;
        desc_type_o <= type_i;
        desc_offset_o <= next_q;
        next_q <= next_q + 5'h01;
        left_q <= left_q - 5'h01;
        gap_q <= 1'b1;
      end
    end
endmodule // hub_host_model

// ### hub_descriptor_attach_logic_tb.sv
`timescale 1ns/1ps
`include "hub_desc_map.vh"
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %0s exp %0h got %0h", n, e, g); end end
module hub_descriptor_attach_logic_tb;
  reg clock_i, nrst_i, mem_wr_i, mem_done_i, mem_valid_i, go, slow, vbus, pv;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr, mem_addr_i, mem_data_i, h_type, pt;
  reg [7:0] b1, mbp, msp;
  reg [31:0] s_axi_wdata, rd;
  reg [15:0] vid, pid, rel;
  reg [95:0] rnd;
  reg [71:0] im;
  reg [4:0] h_cnt, po;
  reg [3:0] s_axi_wstrb;
  integer errors, comparisons, cyc, seed, len, k;
  wire [7:0] desc_type_i, desc_data_o;
  wire [4:0] desc_offset_i, desc_len_o;
  wire [1:0] s_axi_bresp, s_axi_rresp, port_power_o;
  wire [31:0] s_axi_rdata;
  wire desc_rd_i, upstream_power_sense_i, busy, s_axi_awready, s_axi_wready;
  wire s_axi_bvalid, s_axi_arready, s_axi_rvalid, desc_valid_o, desc_err_o;
  wire dplus_pullup_o, hs_enable_o;
  // Identity defaults are arbitrary values
  hub_descriptor_attach_logic #(.DEF_VENDOR(16'h2B6D),
    .DEF_PRODUCT(16'h71E4), .SILICON_REV(8'h3C)) u_dut (.clock_i, .nrst_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mem_wr_i, .mem_addr_i, .mem_data_i,
    .mem_done_i, .mem_valid_i, .desc_rd_i, .desc_type_i, .desc_offset_i,
    .desc_data_o, .desc_valid_o, .desc_err_o, .desc_len_o,
    .upstream_power_sense_i, .dplus_pullup_o, .hs_enable_o, .port_power_o);
  hub_host_model u_host (.clock_i, .nrst_i, .go_i(go), .slow_i(slow),
    .vbus_i(vbus), .type_i(h_type), .count_i(h_cnt), .busy_o(busy),
    .desc_rd_o(desc_rd_i), .desc_type_o(desc_type_i),
    .desc_offset_o(desc_offset_i),
    .upstream_power_sense_o(upstream_power_sense_i));
  function [7:0] expb(input [7:0] t, input [4:0] o);
    reg [199:0] v;
    begin
      if (t == 8'h01)
        v = {64'h1201000209000040, vid[7:0], vid[15:8], pid[7:0], pid[15:8],
          rel[7:0], rel[15:8], 32'h00000001, 56'h0};
      else
        v = {56'h09021900010100, b1[7] ? 8'hE0 : 8'hA0, b1[7] ? msp : mbp,
          72'h090400000109000000, 56'h070581030100FF};
      expb = v[199 - 8 * o -: 8];
    end
  endfunction
  task wrap_up;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task load(input v);
    begin
      for (k = 0; k < 9; k++)
      begin
        @(posedge clock_i);
        mem_wr_i <= 1'b1;
        mem_addr_i <= 8'h20 + k[7:0];
        mem_data_i <= im[8 * k +: 8];
      end
      @(posedge clock_i);
      {mem_wr_i, mem_valid_i, mem_done_i} <= {1'b0, v, 1'b1};
      @(posedge clock_i);
      mem_done_i <= 1'b0;
      vbus <= 1'b1;
      for (k = 0; k < 20 && !dplus_pullup_o; k++)
        @(posedge clock_i);
      `CHK("pullup", dplus_pullup_o, 1'b1) // attach
    end
  endtask
  task fetch(input [7:0] t, input [4:0] n);
    begin
      @(posedge clock_i);
      {h_type, h_cnt, go} <= {t, n, 1'b1};
      @(posedge clock_i);
      go <= 1'b0;
      @(posedge clock_i);
      while (busy)
        @(posedge clock_i);
      repeat (3) @(posedge clock_i);
    end
  endtask
  task axi(input w, input [7:0] a, input [31:0] d, input [1:0] r);
    begin
      @(posedge clock_i);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {w, w, w};
      {s_axi_arvalid, s_axi_rready} <= {!w, !w};
      do
      begin
        @(posedge clock_i);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!(w ? s_axi_bvalid : s_axi_rvalid));
      {s_axi_bready, s_axi_rready} <= 2'h0;
      rd = s_axi_rdata;
      `CHK("resp", w ? s_axi_bresp : s_axi_rresp, r) // decode
    end
  endtask
  always @(posedge clock_i)
  begin
    cyc = cyc + 1;
    if (cyc > 3000)
    begin
      errors++;
      wrap_up;
    end
    len = pt == 8'h01 ? 18 : pt == 8'h02 ? 25 : 0;
    if (pv && po < len)
    begin
      `CHK("valid", desc_valid_o, 1'b1) // answer
      `CHK("data", desc_data_o, expb(pt, po)) // byte order
      `CHK("len", desc_len_o, len[4:0]) // length
    end
    else if (pv)
      `CHK("err", desc_err_o, 1'b1) // refusal
    {pv, pt, po} = {desc_rd_i & nrst_i, desc_type_i, desc_offset_i};
  end
  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial
  begin
    {errors, comparisons, cyc, seed, pv} = {96'h0, 32'd73706, 1'b0};
    {nrst_i, mem_wr_i, mem_done_i, mem_valid_i, go, slow, vbus} = 7'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
    {mem_addr_i, mem_data_i, h_type, h_cnt, s_axi_wstrb} = 33'h1F;
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    rnd = {$random(seed), $random(seed), $random(seed)};
    im = rnd[71:0];
    {vid, pid, rel} = {16'h2B6D, 16'h71E4, 8'h3C, `REL_LO_RESET};
    {b1, mbp, msp} = {`B1_RESET, `MAX_BP_RESET, `MAX_SP_RESET};
    @(posedge clock_i);
    `CHK("pullup", dplus_pullup_o, 1'b0) // no bus power
    load(1'b0);
    fetch(8'h01, 5'h14);
    fetch(8'h02, 5'h19);
    fetch(8'h03, 5'h01);
    `CHK("hs", hs_enable_o, 1'b1) // speed
    axi(1'b1, `REG_CTRL, 32'h3, `RESP_OKAY);
    `CHK("power", port_power_o, 2'h3) // polarity
    axi(1'b0, `REG_STATUS, 32'h0, `RESP_OKAY);
    `CHK("status", rd, 32'hF) // attached
    axi(1'b1, 8'h20, rnd[95:64], `RESP_OKAY);
    axi(1'b0, 8'h20, 32'h0, `RESP_OKAY);
    `CHK("image", rd, {pid, vid}) // defaults
    axi(1'b0, 8'h40, 32'h0, `RESP_SLVERR);
    axi(1'b1, 8'h41, 32'h0, `RESP_SLVERR);
    vbus <= 1'b0;
    repeat (6) @(posedge clock_i);
    `CHK("detach", {dplus_pullup_o, port_power_o}, 3'h0) // detach
    $display("test defaults finished");
    nrst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    rnd = {$random(seed), $random(seed), $random(seed)};
    {vid, pid, rel, mbp, msp, b1} = {rnd[63:0], 8'h20};
    im = {msp, mbp, b1, rel, pid, vid};
    slow <= 1'b1;
    load(1'b1);
    fetch(8'h01, 5'h12);
    fetch(8'h02, 5'h19);
    `CHK("hs", hs_enable_o, 1'b0) // speed
    $display("test loaded finished");
    wrap_up;
  end
endmodule // hub_descriptor_attach_logic_tb
